// ---- rtl/eac_pkg.sv ----
// Package of constants and types for the nonvolatile memory access control
`default_nettype none
package eac_pkg;
  // Capacity and widths
  localparam int unsigned DEPTH        = 512;
  localparam int unsigned ADDR_W       = 9;
  localparam int unsigned DATA_W       = 8;
  // I/O addresses of the registers
  localparam logic [5:0]  IO_CONTROL   = 6'h1c;
  localparam logic [5:0]  IO_DATA      = 6'h1d;
  localparam logic [5:0]  IO_ADDR_LO   = 6'h1e;
  localparam logic [5:0]  IO_ADDR_HI   = 6'h1f;
  localparam logic [6:0]  DS_OFFSET    = 7'h20;
  // Control register fields
  localparam int unsigned BIT_READ     = 0;
  localparam int unsigned BIT_STRIKE   = 1;
  localparam int unsigned BIT_MPE      = 2;
  localparam int unsigned BIT_RIE      = 3;
  localparam int unsigned BIT_MODE_LO  = 4;
  localparam int unsigned BIT_MODE_HI  = 5;
  localparam logic [7:0]  CTRL_RD_MASK = 8'h3f;
  // Modes
  localparam logic [1:0]  MODE_ATOMIC  = 2'h0;
  localparam logic [1:0]  MODE_ERASE   = 2'h1;
  localparam logic [1:0]  MODE_WRITE   = 2'h2;
  localparam logic [1:0]  MODE_RSVD    = 2'h3;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  // Timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned MPE_CYCLES   = 4;
  localparam int unsigned READ_STALL   = 4;
  localparam int unsigned PROG_STALL   = 2;
  localparam int unsigned ATOMIC_US    = 3400;
  localparam int unsigned SPLIT_US     = 1800;
  localparam int unsigned TICK_NS      = 1000;
  localparam int unsigned CLK_NS       = 1000 / CLK_MHZ;
  localparam int unsigned TICK_DIV     = TICK_NS / CLK_NS;
  localparam logic [11:0] ATOMIC_TICKS = 12'(ATOMIC_US);
  localparam logic [11:0] SPLIT_TICKS  = 12'(SPLIT_US);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} eac_prog_type;
endpackage
`default_nettype wire

// ---- rtl/eac_timer_if.sv ----
// Interface between controller and programming timer
`default_nettype none
interface eac_timer_if;
  logic        start;
  logic [11:0] ticks;
  logic        done;
  modport ctrl  (output start, output ticks, input done);
  modport timer (input start, input ticks, output done);
endinterface
`default_nettype wire

// ---- rtl/eac_timer.sv ----
// Self-timed programming duration counter
`default_nettype none
module eac_timer
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic   clock,
  input wire logic   srst,
  // Controller side
  eac_timer_if.timer tif
);
  typedef struct packed {
    logic [7:0]  div;
    logic [11:0] left;
    logic        run;
    logic        done;
  } eac_tstate_type;
  eac_tstate_type s_reg, s_next;

  // Microsecond tick base, independent of core instruction rate
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (tif.start) begin
      s_next.run = 1'b1;
      s_next.left = tif.ticks;
      s_next.div = 8'h0;
    end else if (s_reg.run) begin
      if (s_reg.div == 8'(TICK_DIV - 1)) begin
        s_next.div = 8'h0;
        if (s_reg.left == 12'h1) begin
          s_next.run = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.left = s_reg.left - 12'h1;
        end
      end else begin
        s_next.div = s_reg.div + 8'h1;
      end
    end
    // Reset parks an idle timer; a running count carries on
    if (srst && !tif.start) begin
      unique case (s_reg.run)
        1'b1: ;
        default: s_next = '0;
      endcase
    end
  end

  // Not reset: a running operation survives reset
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end
  assign tif.done = s_reg.done;
endmodule // eac_timer
`default_nettype wire

// ---- rtl/eac_ctrl.sv ----
// Nonvolatile byte memory access control with core register interface
`default_nettype none
module eac_ctrl
  import eac_pkg::*;
(
  // Clock and reset
  input wire logic               clock,
  input wire logic               srst,
  // Core I/O access
  input wire logic               io_wr,
  input wire logic               io_rd,
  input wire logic               io_data_space,
  input wire logic [6:0]         io_addr,
  input wire logic [7:0]         io_wdata,
  output logic     [7:0]         io_rdata,
  // Core control
  input wire logic               global_irq_enable,
  output logic                   core_stall,
  output logic                   ready_irq
);
  typedef struct packed {
    logic [1:0]        mode;
    logic              rie;
    logic              mpe;
    logic [2:0]        mpe_cnt;
    logic              strike;
    logic [1:0]        op_mode;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic [7:0]        rdata;
    logic [2:0]        stall_cnt;
    logic              stall;
    logic              irq;
    logic              tstart;
    logic [11:0]       tticks;
  } eac_state_type;
  eac_state_type s_reg, s_next;
  eac_prog_type  prog_reg, prog_next;

  logic [7:0] mem [DEPTH];
  logic       mem_we;
  logic [7:0] mem_wv;

  eac_timer_if tif ();
  eac_timer u_timer (
    .clock (clock),
    .srst  (srst),
    .tif   (tif.timer)
  );
  assign tif.start = s_reg.tstart;
  assign tif.ticks = s_reg.tticks;

  // Strip data space offset
  function automatic logic [5:0] io_index(input logic [6:0] a,
                                          input logic ds);
    logic [6:0] t;
    t = ds ? (a - DS_OFFSET) : a;
    return t[5:0];
  endfunction

  function automatic logic [11:0] mode_ticks(input logic [1:0] m);
    return (m == MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
  endfunction

  function automatic logic [7:0] ctrl_view(input eac_state_type s);
    logic [7:0] v;
    v = 8'h0;
    v[BIT_MODE_HI:BIT_MODE_LO] = s.mode;
    v[BIT_RIE] = s.rie;
    v[BIT_MPE] = s.mpe;
    v[BIT_STRIKE] = s.strike;
    return v & CTRL_RD_MASK;
  endfunction

  logic [5:0] idx;
  logic       hit_ok;
  logic       busy;
  logic [7:0] wd;
  always_comb begin
    idx = io_index(io_addr, io_data_space);
    hit_ok = !io_data_space || (io_addr >= DS_OFFSET);
    busy = s_reg.strike;
    wd = io_wdata;
    s_next = s_reg;
    prog_next = prog_reg;
    mem_we = 1'b0;
    mem_wv = s_reg.data;
    s_next.tstart = 1'b0;
    // Master enable window
    if (s_reg.mpe) begin
      if (s_reg.mpe_cnt == 3'(MPE_CYCLES - 1)) begin
        s_next.mpe = 1'b0;
      end else begin
        s_next.mpe_cnt = s_reg.mpe_cnt + 3'h1;
      end
    end
    // Stall counter
    if (s_reg.stall_cnt != 3'h0) begin
      s_next.stall_cnt = s_reg.stall_cnt - 3'h1;
    end
    s_next.stall = (s_next.stall_cnt != 3'h0);
    if (io_wr && hit_ok) begin
      unique case (idx)
        IO_CONTROL: begin
          s_next.rie = wd[BIT_RIE];
          if (!busy) begin
            s_next.mode = wd[BIT_MODE_HI:BIT_MODE_LO];
          end
          if (wd[BIT_MPE] && !s_reg.mpe) begin
            s_next.mpe = 1'b1;
            s_next.mpe_cnt = 3'h0;
          end
          if (wd[BIT_STRIKE] && s_reg.mpe && !busy) begin
            s_next.strike = 1'b1;
            s_next.mpe = 1'b0;
            s_next.op_mode = s_reg.mode;
            s_next.tstart = 1'b1;
            s_next.tticks = mode_ticks(s_reg.mode);
            s_next.stall_cnt = 3'(PROG_STALL);
            s_next.stall = 1'b1;
            prog_next = ST_BUSY;
          end else if (wd[BIT_READ] && !busy) begin
            s_next.data = mem[s_reg.addr];
            s_next.stall_cnt = 3'(READ_STALL);
            s_next.stall = 1'b1;
          end
        end
        IO_DATA: s_next.data = wd;
        IO_ADDR_LO: begin
          if (!busy) begin
            s_next.addr[7:0] = wd;
          end
        end
        IO_ADDR_HI: begin
          if (!busy) begin
            s_next.addr[ADDR_W-1:8] = wd[ADDR_W-9:0];
          end
        end
        default: ;
      endcase
    end
    // Programming completion
    unique case (prog_reg)
      ST_IDLE: ;
      ST_BUSY: begin
        if (tif.done) begin
          prog_next = ST_DONE;
        end
      end
      ST_DONE: begin
        mem_we = (s_reg.op_mode != MODE_RSVD);
        unique case (s_reg.op_mode)
          MODE_ERASE: mem_wv = ERASED_BYTE;
          MODE_WRITE: mem_wv = mem[s_reg.addr] & s_reg.data;
          default:    mem_wv = s_reg.data;
        endcase
        s_next.strike = 1'b0;
        prog_next = ST_IDLE;
      end
      default: ;
    endcase
    if (io_rd && hit_ok) begin
      unique case (idx)
        IO_CONTROL: s_next.rdata = ctrl_view(s_next);
        IO_DATA:    s_next.rdata = s_reg.data;
        IO_ADDR_LO: s_next.rdata = s_reg.addr[7:0];
        IO_ADDR_HI: s_next.rdata = 8'(s_reg.addr[ADDR_W-1:8]);
        default:    s_next.rdata = 8'h0;
      endcase
    end
    s_next.irq = s_next.rie && global_irq_enable && !s_next.strike;
    // Reset keeps running operation
    if (srst) begin
      s_next.rie = 1'b0;
      s_next.mpe = 1'b0;
      s_next.mpe_cnt = 3'h0;
      s_next.stall_cnt = 3'h0;
      s_next.stall = 1'b0;
      s_next.irq = 1'b0;
      s_next.rdata = 8'h0;
      // Unknown state at power-up counts as idle
      unique case (prog_reg)
        ST_BUSY, ST_DONE: ;
        default: begin
          s_next.mode = MODE_ATOMIC;
          s_next.strike = 1'b0;
          s_next.addr = '0;
          s_next.data = 8'h0;
          s_next.tstart = 1'b0;
          s_next.op_mode = MODE_ATOMIC;
          s_next.tticks = 12'h0;
          prog_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
    prog_reg <= prog_next;
    if (mem_we) begin
      mem[s_reg.addr] <= mem_wv;
    end
  end

  assign io_rdata = s_reg.rdata;
  assign core_stall = s_reg.stall;
  assign ready_irq = s_reg.irq;
endmodule // eac_ctrl
`default_nettype wire

// ---- bench/eac_asserts.sv ----
// Port checker for the memory access control
`default_nettype none
module eac_asserts (
  // Clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // Core access
  input wire logic       io_wr,
  input wire logic       io_rd,
  input wire logic       io_data_space,
  input wire logic [6:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Core control
  input wire logic       global_irq_enable,
  input wire logic       core_stall,
  input wire logic       ready_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] age_reg;
  wire logic hit = io_addr == (io_data_space ? 7'h3c : 7'h1c);
  wire logic wr_c = io_wr && hit;
  wire logic go = wr_c && io_wdata[3:0] == 4'ha && ready_irq;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  // Cycles since master enable was written
  always_ff @(posedge clock)
    if (srst) age_reg <= 3'h7;
    else if (wr_c && io_wdata[2]) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  a_read_stall: assert property (
    wr_c && io_wdata[0] && ready_irq |=> core_stall [*4] ##1 !core_stall)
    else $error("read stall");
  a_prog_stall: assert property (
    go && age_reg < 3'h2 |=> core_stall [*2] ##1 !core_stall)
    else $error("program stall");
  a_busy_irq: assert property (
    go && age_reg < 3'h2 |=> ##1 !ready_irq [*8]) else $error("busy irq");
  a_strike_refused: assert property (
    go && age_reg == 3'h7 |=> ready_irq && !core_stall) else $error("strike");
  a_irq_global: assert property (
    ready_irq |-> $past(global_irq_enable)) else $error("irq global");
  a_irq_off: assert property (
    wr_c && !io_wdata[3] |=> ##1 !ready_irq) else $error("irq off");
  a_reset_clear: assert property (
    $fell(srst) |-> io_rdata == 8'h00 && !core_stall && !ready_irq)
    else $error("reset values");
  a_reserved_zero: assert property (
    io_rd && hit |=> io_rdata[7:6] == 2'h0) else $error("reserved bits");
  a_unmapped_zero: assert property (
    io_rd && !io_data_space && io_addr == 7'h10 |=> io_rdata == 8'h00)
    else $error("unmapped read");
  c_read: cover property (wr_c && io_wdata[0] && ready_irq);
  c_prog: cover property (go && age_reg < 3'h2);
  c_refuse: cover property (go && age_reg == 3'h7);
endmodule // eac_asserts
bind eac_ctrl eac_asserts u_eac_asserts (.clock, .srst, .io_wr, .io_rd,
  .io_data_space, .io_addr, .io_wdata, .io_rdata, .global_irq_enable,
  .core_stall, .ready_irq);
`default_nettype wire

// ---- bench/eac_core_model.sv ----
// Processor core model issuing I/O accesses
`default_nettype none
module eac_core_model (
  // Clock
  input wire logic        clock,
  // Core access
  output var logic        io_wr,
  output var logic        io_rd,
  output var logic        io_data_space,
  output var logic [6:0]  io_addr,
  output var logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        core_stall
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_data_space = 1'h0;
    io_addr = 7'h00;
    io_wdata = 8'h00;
  end
  // One access held for one edge, never issued while stalled
  task automatic acc(input logic w, input logic ds, input logic [6:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    #1;
    while (core_stall === 1'h1) begin
      @(posedge clock);
      #1;
    end
    io_wr = w;
    io_rd = !w;
    io_data_space = ds;
    io_addr = ds ? a + 7'h20 : a;
    io_wdata = d;
    @(posedge clock);
    #1;
    q = io_rdata;
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_wdata = ~d;
  endtask
  // Master enable, then strike
  task automatic prog(input logic [1:0] m);
    logic [7:0] q;
    acc(1'h1, 1'h0, 7'h1c, {2'h0, m, 4'hc}, q);
    acc(1'h1, 1'h0, 7'h1c, {2'h0, m, 4'ha}, q);
  endtask
endmodule // eac_core_model
`default_nettype wire

// ---- bench/test_eac_ctrl.sv ----
// Testbench for the memory access control
`default_nettype none
module test_eac_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock = 1'h0;
  logic       srst = 1'h1;
  logic       global_irq_enable = 1'h0;
  logic       io_wr, io_rd, io_data_space, core_stall, ready_irq;
  logic [6:0] io_addr;
  logic [7:0] io_wdata, io_rdata, q;
  int         fail_count = 0;
  int         comparisons = 0;
  always #2.5 clock = ~clock;
  eac_ctrl u_eac_ctrl (.clock, .srst, .io_wr, .io_rd, .io_data_space,
    .io_addr, .io_wdata, .io_rdata, .global_irq_enable, .core_stall,
    .ready_irq);
  eac_core_model u_eac_core_model (.clock, .io_wr, .io_rd, .io_data_space,
    .io_addr, .io_wdata, .io_rdata, .core_stall);
  task automatic check(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, ds = 1'h0);
    u_eac_core_model.acc(1'h1, ds[0], a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, string n);
    u_eac_core_model.acc(1'h0, 1'h0, a, 8'h00, q);
    check(n, q, e);
  endtask
  task automatic stalls(input int n);
    int k = 0;
    repeat (8) begin
      k += int'(core_stall === 1'h1);
      @(posedge clock);
      #1;
    end
    check("stall", 8'(k), 8'(n));
  endtask
  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_modes;
    rd(7'h1c, 8'h00, "ctrl reset");
    for (int m = 0; m < 4; m++) begin
      wr(7'h1c, {2'h3, 2'(m), 4'h0}, 1'h1);
      rd(7'h1c, {2'h0, 2'(m), 4'h0}, "mode");
    end
    rd(7'h10, 8'h00, "unmapped");
  endtask
  task automatic t_read;
    wr(7'h1e, 8'ha5);
    wr(7'h1f, 8'h01);
    rd(7'h1e, 8'ha5, "addr lo");
    rd(7'h1f, 8'h01, "addr hi");
    wr(7'h1c, 8'h08);
    check("irq masked", {7'h0, ready_irq}, 8'h00);
    global_irq_enable = 1'h1;
    repeat (3) @(posedge clock);
    #1;
    check("irq", {7'h0, ready_irq}, 8'h01);
    wr(7'h1c, 8'h09);
    stalls(4);
  endtask
  task automatic t_guard;
    wr(7'h1c, 8'h0a);
    stalls(0);
    rd(7'h1c, 8'h08, "no enable");
    wr(7'h1c, 8'h0c);
    repeat (6) @(posedge clock);
    rd(7'h1c, 8'h08, "enable clear");
    wr(7'h1c, 8'h0a);
    rd(7'h1c, 8'h08, "late strike");
  endtask
  task automatic t_prog;
    rd(7'h1c, 8'h08, "idle poll");
    wr(7'h1d, 8'h5a);
    u_eac_core_model.prog(2'h2);
    stalls(2);
    rd(7'h1c, 8'h2a, "busy");
    wr(7'h1c, 8'h1a);
    rd(7'h1c, 8'h2a, "mode lock");
    wr(7'h1e, 8'h3c);
    rd(7'h1e, 8'ha5, "addr lock");
    wr(7'h1c, 8'h2b);
    rd(7'h1d, 8'h5a, "read block");
    srst = 1'h1;
    repeat (2) @(posedge clock);
    #1;
    srst = 1'h0;
    rd(7'h1c, 8'h22, "reset busy");
    rd(7'h1e, 8'ha5, "addr kept");
    rd(7'h1d, 8'h5a, "data kept");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1;
    srst = 1'h0;
    t_modes();
    t_read();
    t_guard();
    t_prog();
    end_sim();
  end
  // Watchdog
  initial begin
    #10000;
    fail_count++;
    end_sim();
  end
endmodule // test_eac_ctrl
`default_nettype wire
